// ==== core/ipfm_pkg.sv ====
// Package: register map, field layouts, reset values and timing for the position monitor
package ipfm_pkg;
  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_WINDOW   = 8'h00;
  localparam logic [7:0] OFF_DWELL    = 8'h04;
  localparam logic [7:0] OFF_FAULT    = 8'h08;
  localparam logic [7:0] OFF_INHIBIT  = 8'h0C;
  localparam logic [7:0] OFF_LOCK     = 8'h10;
  localparam logic [7:0] OFF_MOTLIM   = 8'h14;
  localparam logic [7:0] OFF_IDLECUR  = 8'h18;
  localparam logic [7:0] OFF_IDLEDLY  = 8'h1C;
  localparam logic [7:0] OFF_CTRL     = 8'h20;
  localparam logic [7:0] OFF_STATUS   = 8'h24;
  localparam logic [7:0] OFF_IRQSTAT  = 8'h28;
  localparam logic [7:0] OFF_IRQMASK  = 8'h2C;
  localparam logic [7:0] OFF_POSERR   = 8'h30;

  // ****************************************************************
  // Limits and reset values
  // ****************************************************************
  localparam logic [14:0] WINDOW_MAX    = 15'h7FFF;
  localparam logic [14:0] DWELL_MAX     = 15'h7530;
  localparam logic [14:0] DWELL_RST     = 15'h000A;
  localparam logic [14:0] FAULT_MIN     = 15'h0001;
  localparam logic [14:0] FAULT_RST     = 15'h7FFF;
  localparam logic [6:0]  TORQUE_MAX    = 7'h64;
  localparam logic [1:0]  INHIBIT_RST   = 2'h3;
  localparam logic [1:0]  INH_CLOSED    = 2'h1;
  localparam logic [1:0]  INH_OPEN      = 2'h2;
  localparam logic [3:0]  MODE_STEPDIR  = 4'h7;
  localparam logic [14:0] WINDOW_RST    = 15'h000A;
  localparam logic [14:0] MOTLIM_RST    = 15'h000A;
  localparam logic [15:0] IDLECUR_RST   = 16'h0000;
  localparam logic [15:0] IDLEDLY_RST   = 16'h0032;

  // ****************************************************************
  // Control / status bit positions
  // ****************************************************************
  localparam int CTRL_STEPPER = 0;
  localparam int CTRL_ALTTICK = 1;
  localparam int CTRL_MODE_LO = 4;
  localparam int IRQ_INPOS    = 0;
  localparam int IRQ_FAULT    = 1;
  localparam int IRQ_NVSAVE   = 2;
  localparam int IRQ_BITS     = 3;

  // ****************************************************************
  // Tick timing: control cycle in ns and the derived count
  // ****************************************************************
  localparam int CLK_NS       = 5;
  localparam int TICK_NS      = 200000;
  localparam int TICK_ALT_NS  = 250000;
  localparam int TICK_CYC     = TICK_NS / CLK_NS;
  localparam int TICK_ALT_CYC = TICK_ALT_NS / CLK_NS;

  // Non-volatile save request travelling out of the block
  typedef struct packed {
    logic        req;
    logic [15:0] data;
  } ipfm_nv_t;
endpackage

// ==== core/ipfm_top.sv ====
// Position supervision block: in-position dwell, fault, motion output, inhibit, idle current
// Notes on behaviour
// - In position only after error stays inside window for full dwell time.
// - Dwell counted in control ticks of 200 us, or 250 us alternate.
// - Dwell setting read/write, range 0 to 30000, default 10 ticks.
// - In-position window is a static count limit, host settable and readable.
// - Servo: fault raised when following error reaches limit 1 to 32767.
// - Stepper: setting is stall torque 0 to 100, used after save and repower; torque in use is always 127, taken from the register's reset value.
// - Inhibit selector 1 closed, 2 open, 3 general input; default 3.
// - Inhibit acts only on pulse position command in step-direction mode 7.
// - Panel lock 0 allows front panel edits, 1 refuses; default 0.
// - Servo: motion output held during move until error within limit.
// - In-position status bit uses the same positioning-limit criterion.
// - Stepper: idle current only after delay since last step.
// - Idle current write updates level and commits to storage at once.
// - Window accepts limits 0 to 32767 counts.
`timescale 1ns/10ps
`default_nettype none
module ipfm_top #(
  parameter int TICK_CYCLES     = ipfm_pkg::TICK_CYC,     // Normal tick length
  parameter int TICK_ALT_CYCLES = ipfm_pkg::TICK_ALT_CYC  // Alternate tick length
) (
  input  wire logic        sys_clk,        // 200 MHz clock
  input  wire logic        rst_b,          // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic [15:0] posError,       // Signed following error, same clock
  input  wire logic        moving,         // Move in progress, same clock
  input  wire logic        stepPulse,      // Step issued, same clock
  input  wire logic        pulseCmdIn,     // Pulse position command in, same clock
  input  wire logic        inhibitInput,   // Inhibit pin, asynchronous
  input  wire logic        panelWrReq,     // Front panel edit request
  output logic             panelWrAllow,   // Panel edit granted
  output logic             pulseCmdOut,    // Gated pulse command
  output logic             inPosition,     // Dwell-qualified in-position flag
  output logic             motionOut,      // Motion output
  output logic             positionFault,  // Position fault error
  output logic             idleActive,     // Phase current at idle level
  output logic      [15:0] idleCurrent,    // Active idle level
  output logic      [6:0]  stallTorque,    // Stall torque in use (after repower)
  output var ipfm_pkg::ipfm_nv_t nvSave,   // Non-volatile commit request
  output logic             irq             // Level interrupt
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Settings: a refused write leaves these untouched
  logic [14:0] windowQ, dwellQ, faultQ, motLimQ;
  logic [1:0]  inhibitQ;
  logic        lockQ;
  logic [15:0] idleCurQ, idleDlyQ;
  logic [7:0]  ctrlQ;
  localparam int IPFM_B = ipfm_pkg::IRQ_BITS;
  logic [IPFM_B-1:0] irqStatQ, irqMaskQ;
  // Stall torque in use and the flag that it has been loaded
  logic [6:0]  torqueNvQ;
  logic        torqueLoaded;
  // Inhibit pin synchroniser, two stages
  logic [1:0]  inhSync;
  // Tick divider: 18 bits hold the longer 250 us tick at 200 MHz
  logic [17:0] tickCntQ;
  // Dwell count stops one past the setting, so 15 bits still suffice
  logic [14:0] dwellCntQ;
  // Idle count stops one past the setting, hence one bit wider
  logic [16:0] idleCntQ;
  // Internal copies of status, read back through the status word
  logic        inPosQ, nearQ, faultQ_s;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Writes land at the access edge only; a read is sampled at setup so
  // the registered data stands through the single access cycle
  wire         wrEn   = psel & penable & pwrite;
  wire         rdPh   = psel & ~penable & ~pwrite;
  wire         hit    = (paddr <= ipfm_pkg::OFF_POSERR) && (paddr[1:0] == 2'h0);
  wire         wrWin  = wrEn && paddr == ipfm_pkg::OFF_WINDOW;
  wire         wrDwl  = wrEn && paddr == ipfm_pkg::OFF_DWELL;
  wire         wrFlt  = wrEn && paddr == ipfm_pkg::OFF_FAULT;
  wire         wrInh  = wrEn && paddr == ipfm_pkg::OFF_INHIBIT;
  wire         wrLck  = wrEn && paddr == ipfm_pkg::OFF_LOCK;
  wire         wrMlm  = wrEn && paddr == ipfm_pkg::OFF_MOTLIM;
  wire         wrIcr  = wrEn && paddr == ipfm_pkg::OFF_IDLECUR;
  wire         wrIdl  = wrEn && paddr == ipfm_pkg::OFF_IDLEDLY;
  wire         wrCtl  = wrEn && paddr == ipfm_pkg::OFF_CTRL;
  wire         wrIst  = wrEn && paddr == ipfm_pkg::OFF_IRQSTAT;
  wire         wrMsk  = wrEn && paddr == ipfm_pkg::OFF_IRQMASK;
  // Variant and control mode come from the control register
  wire         stepper = ctrlQ[ipfm_pkg::CTRL_STEPPER];
  wire  [3:0]  ctlMode = ctrlQ[ipfm_pkg::CTRL_MODE_LO +: 4];

  // Out-of-range values are refused: the register keeps its old value
  // Refusing instead of clamping keeps a bad host value from quietly
  // becoming a different limit than the host believes it wrote
  // Unmapped places raise the error flag; read-only ones drop the write
  // dwell range
  wire dwlOk = pwdata[31:15] == 17'h0 && pwdata[14:0] <= ipfm_pkg::DWELL_MAX;
  wire winOk = pwdata[31:15] == 17'h0;
  // One register serves both variants: the stepper bit picks the range
  // fault limit range, torque range on stepper
  wire fltOk = pwdata[31:15] == 17'h0 && (stepper ?
               pwdata[14:0] <= {8'h00, ipfm_pkg::TORQUE_MAX} :
               pwdata[14:0] >= ipfm_pkg::FAULT_MIN);
  wire inhOk = pwdata[31:2] == 30'h0 && pwdata[1:0] != 2'h0;
  wire lckOk = pwdata[31:1] == 31'h0;
  wire mlmOk = pwdata[31:15] == 17'h0;

  // Read mux
  // Unmapped offsets read as zero; the error flag tells the host why
  logic [31:0] rdMux;
  always_comb begin
    case (paddr)
      ipfm_pkg::OFF_WINDOW:  rdMux = {17'h0, windowQ};
      ipfm_pkg::OFF_DWELL:   rdMux = {17'h0, dwellQ};
      ipfm_pkg::OFF_FAULT:   rdMux = {17'h0, faultQ};
      ipfm_pkg::OFF_INHIBIT: rdMux = {30'h0, inhibitQ};
      ipfm_pkg::OFF_LOCK:    rdMux = {31'h0, lockQ};
      ipfm_pkg::OFF_MOTLIM:  rdMux = {17'h0, motLimQ};
      ipfm_pkg::OFF_IDLECUR: rdMux = {16'h0, idleCurQ};
      ipfm_pkg::OFF_IDLEDLY: rdMux = {16'h0, idleDlyQ};
      ipfm_pkg::OFF_CTRL:    rdMux = {24'h0, ctrlQ};
      // Status word: idle, fault, near limit, in position, inhibit pin
      ipfm_pkg::OFF_STATUS:  rdMux = {27'h0, idleActive, faultQ_s, nearQ, inPosQ, inhSync[1]};
      ipfm_pkg::OFF_IRQSTAT: rdMux = {29'h0, irqStatQ};
      ipfm_pkg::OFF_IRQMASK: rdMux = {29'h0, irqMaskQ};
      ipfm_pkg::OFF_POSERR:  rdMux = {16'h0, posError};
      default:               rdMux = 32'h0;
    endcase
  end

  // Bus answer: pready one cycle after setup, so every access has one wait-free access phase
  // Ready depends only on the setup cycle, so no address decode sits in its path
  // The error flag is formed in that same setup cycle from the decoded address
  // Read data is latched at setup and so reflects the state one cycle early
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= rdPh ? rdMux : prdata;
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
    end
  end

  // Settings registers
  // Defaults other than lock, control and mask come from the package so software and logic agree
  // Each setting has its own write strobe; all but idle level, idle delay, control and mask have a range check
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      windowQ  <= ipfm_pkg::WINDOW_RST;
      dwellQ   <= ipfm_pkg::DWELL_RST;
      faultQ   <= ipfm_pkg::FAULT_RST;
      inhibitQ <= ipfm_pkg::INHIBIT_RST;
      lockQ    <= 1'b0;
      motLimQ  <= ipfm_pkg::MOTLIM_RST;
      idleCurQ <= ipfm_pkg::IDLECUR_RST;
      idleDlyQ <= ipfm_pkg::IDLEDLY_RST;
      ctrlQ    <= 8'h00;
      irqMaskQ <= 3'h0;
    end else begin
      if (wrWin && winOk) windowQ <= pwdata[14:0];
      if (wrDwl && dwlOk) dwellQ <= pwdata[14:0];
      // fault limit, shared with the stepper torque setting
      if (wrFlt && fltOk) faultQ <= pwdata[14:0];
      if (wrInh && inhOk) inhibitQ <= pwdata[1:0];
      if (wrLck && lckOk) lockQ <= pwdata[0];
      if (wrMlm && mlmOk) motLimQ <= pwdata[14:0];
      // idle level takes effect at once
      if (wrIcr) idleCurQ <= pwdata[15:0];
      if (wrIdl) idleDlyQ <= pwdata[15:0];
      if (wrCtl) ctrlQ <= pwdata[7:0];
      if (wrMsk) irqMaskQ <= pwdata[2:0];
    end
  end

  // ****************************************************************
  // Position supervision
  // ****************************************************************
  // The error magnitude is taken once and shared by all three compares;
  // the most negative error maps to 32768, which trips every limit
  wire [15:0] absErr  = posError[15] ? 16'(-posError) : posError;
  // Window and limit compares include the end point: equal counts as inside
  wire        inWin   = absErr <= {1'b0, windowQ};
  wire        inLim   = absErr <= {1'b0, motLimQ};
  // fault only on servo; on a stepper the register holds torque
  wire        fltHit  = ~stepper && absErr >= {1'b0, faultQ};
  // tick length picks the 200 us or 250 us control cycle
  wire [17:0] tickLen = ctrlQ[ipfm_pkg::CTRL_ALTTICK] ? 18'(TICK_ALT_CYCLES - 1)
                                                      : 18'(TICK_CYCLES - 1);
  wire        tick    = tickCntQ >= tickLen;
  // the free-running tick makes the first counted tick partial, so one
  // extra tick is counted and the dwell is never short; zero needs none
  wire        dwellDone = (dwellQ == 15'h0) || (dwellCntQ > dwellQ);

  // control tick divider
  // Counting to length minus one gives exactly that many cycles per tick
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) tickCntQ <= 18'h0;
    else        tickCntQ <= tick ? 18'h0 : tickCntQ + 18'h1;
  end

  // Dwell counter and in-position flag
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dwellCntQ <= 15'h0;
      inPosQ    <= 1'b0;
    end else begin
      if (!inWin) dwellCntQ <= 15'h0;
      else if (tick && !dwellDone) dwellCntQ <= dwellCntQ + 15'h1;
      inPosQ <= inWin && dwellDone;
    end
  end

  // Motion output, fault and limit-based in-position
  // Motion output drops once the error is inside the limit, even mid-move
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      nearQ     <= 1'b0;
      faultQ_s  <= 1'b0;
      motionOut <= 1'b0;
    end else begin
      // same limit criterion as motion output
      nearQ     <= inLim;
      faultQ_s  <= fltHit;
      // held active in a move until within limit
      motionOut <= moving & ~inLim;
    end
  end

  // ****************************************************************
  // Inhibit, panel, idle current, stall torque
  // ****************************************************************
  // Pin is asynchronous: two-flop sync, only the second stage is read
  // A pin pulse shorter than a clock may be missed; the pin is a level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) inhSync <= 2'h0;
    else        inhSync <= {inhSync[0], inhibitInput};
  end

  // closed / open selection
  // Code 3 matches neither compare, leaving the pin free for general use
  wire inhAct = (inhibitQ == ipfm_pkg::INH_CLOSED &&  inhSync[1]) ||
                (inhibitQ == ipfm_pkg::INH_OPEN   && ~inhSync[1]);
  // only in step-direction mode
  // Outside the step-direction mode the pin never touches the pulse path
  wire blockPulse = inhAct && ctlMode == ipfm_pkg::MODE_STEPDIR;

  // Idle delay counter restarts on each step; stepper only
  // A move in progress counts as stepping even between pulses
  // one extra tick is counted, as for the dwell, so the delay is never short
  wire idleDone = (idleDlyQ == 16'h0) || (idleCntQ > {1'b0, idleDlyQ});
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idleCntQ   <= 17'h0;
      idleActive <= 1'b0;
    end else begin
      if (stepPulse || moving) idleCntQ <= 17'h0;
      else if (tick && !idleDone) idleCntQ <= idleCntQ + 17'h1;
      idleActive <= stepper && !stepPulse && !moving && idleDone;
    end
  end

  // Stall torque sampled once after reset release, standing in for repower
  // The shared register is read at the first edge out of reset; later
  // writes change the register but not the torque in use
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      torqueLoaded <= 1'b0;
      torqueNvQ    <= 7'h0;
    end else if (!torqueLoaded) begin
      torqueLoaded <= 1'b1;
      torqueNvQ    <= faultQ[6:0];
    end
  end

  // Outputs and NV commit
  // Every output is a flop: the one-cycle lag buys clean output timing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulseCmdOut  <= 1'b0;
      panelWrAllow <= 1'b0;
      idleCurrent  <= ipfm_pkg::IDLECUR_RST;
      nvSave       <= '0;
      inPosition   <= 1'b0;
      positionFault <= 1'b0;
      stallTorque  <= 7'h0;
    end else begin
      pulseCmdOut   <= pulseCmdIn & ~blockPulse;
      panelWrAllow  <= panelWrReq & ~lockQ;
      idleCurrent   <= idleCurQ;
      nvSave.req    <= wrIcr;
      // Data follows the bus every cycle; only the cycle with req set counts
      nvSave.data   <= pwdata[15:0];
      inPosition    <= inPosQ;
      positionFault <= faultQ_s;
      stallTorque   <= torqueNvQ;
    end
  end

  // ****************************************************************
  // Interrupts: set wins over write-one-to-clear
  // ****************************************************************
  wire [2:0] irqEv   = {nvSave.req, fltHit & ~faultQ_s, inWin & dwellDone & ~inPosQ};
  wire [2:0] irqClr  = wrIst ? pwdata[2:0] : 3'h0;
  // Status and output share one next value, so the line follows a clear
  // in the very cycle that it lands; a mask write shows one cycle later
  wire [2:0] irqNext = (irqStatQ & ~irqClr) | irqEv;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStatQ <= 3'h0;
      irq      <= 1'b0;
    end else begin
      irqStatQ <= irqNext;
      irq      <= |(irqNext & irqMaskQ);
    end
  end

endmodule
`default_nettype wire

// ==== testbench/ipfm_apb_host.sv ====
// Host model issuing single APB register transfers
`timescale 1ns/10ps
`default_nettype none
module ipfm_apb_host (
  input  wire logic        sys_clk, // Bus clock
  input  wire logic        pready,  // Slave ready
  output logic             psel,    // Select
  output logic             penable, // Enable
  output logic             pwrite,  // Direction
  output logic      [7:0]  paddr,   // Byte address
  output logic      [31:0] pwdata   // Write data
);
  // ****************************************************************
  // Transfer
  // ****************************************************************
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // setup, then access held until ready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait for ready however long it takes; only the bench watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value never looks valid
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== testbench/ipfm_monitor.sv ====
// Checker for bus timing and output causes at the position monitor ports
`timescale 1ns/10ps
`default_nettype none
module ipfm_monitor (
  input wire logic               sys_clk,      // Clock
  input wire logic               rst_b,        // Reset, active low
  input wire logic               psel,         // APB select
  input wire logic               penable,      // APB enable
  input wire logic               pwrite,       // APB direction
  input wire logic [7:0]         paddr,        // APB address
  input wire logic [31:0]        pwdata,       // APB write data
  input wire logic               pready,       // APB ready
  input wire logic               pslverr,      // APB error
  input wire logic               moving,       // Move in progress
  input wire logic               pulseCmdIn,   // Pulse command in
  input wire logic               panelWrReq,   // Panel edit request
  input wire logic               panelWrAllow, // Panel edit grant
  input wire logic               pulseCmdOut,  // Gated pulse command
  input wire logic               motionOut,    // Motion output
  input wire ipfm_pkg::ipfm_nv_t nvSave        // Commit request
);
  // ****************************************************************
  // Relations
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  access_ready_a: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  ready_scope_a: assert property (pready |-> psel && penable)
    else $error("ready outside access cycle");
  bad_addr_a: assert property (psel && penable |-> pslverr == (paddr > 8'h30 || paddr[1:0] != 2'h0))
    else $error("error flag disagrees with address");
  nv_commit_a: assert property (psel && penable && pwrite && paddr == ipfm_pkg::OFF_IDLECUR
    |=> nvSave.req && nvSave.data == $past(pwdata[15:0])) else $error("idle level not committed");
  nv_cause_a: assert property (nvSave.req |-> $past(psel && penable && pwrite
    && paddr == ipfm_pkg::OFF_IDLECUR)) else $error("commit without idle level write");
  panel_grant_a: assert property (panelWrAllow |-> $past(panelWrReq))
    else $error("panel grant without request");
  pulse_gate_a: assert property (pulseCmdOut |-> $past(pulseCmdIn))
    else $error("pulse out without pulse in");
  motion_move_a: assert property (motionOut |-> $past(moving))
    else $error("motion output outside a move");
endmodule
bind ipfm_top ipfm_monitor mon (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .moving, .pulseCmdIn, .panelWrReq, .panelWrAllow, .pulseCmdOut,
  .motionOut, .nvSave);
`default_nettype wire

// ==== testbench/ipfm_top_tb_top.sv ====
// Self-checking bench for the position supervision block
`timescale 1ns/10ps
`default_nettype none
module ipfm_top_tb_top;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, moving, stepPulse;
  logic pulseCmdIn, inhibitInput, panelWrReq, panelWrAllow, pulseCmdOut, inPosition;
  logic motionOut, positionFault, idleActive, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] posError, idleCurrent, idleVal;
  logic [6:0] stallTorque;
  ipfm_pkg::ipfm_nv_t nvSave;
  logic [32:0] expQ[$];
  logic [32:0] e;
  int fails, checked;
  // ****************************************************************
  // Harness
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Short ticks keep dwell and idle delays quick
  ipfm_top #(.TICK_CYCLES(4), .TICK_ALT_CYCLES(5)) uut (.sys_clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .posError, .moving, .stepPulse,
    .pulseCmdIn, .inhibitInput, .panelWrReq, .panelWrAllow, .pulseCmdOut, .inPosition,
    .motionOut, .positionFault, .idleActive, .idleCurrent, .stallTorque, .nvSave, .irq);
  ipfm_apb_host host (.sys_clk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic err);
    expQ.push_back({err, err ? 16'h0000 : 16'hFFFF, d});
    host.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Oldest read note against each read answer
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      e = expQ.pop_front();
      chk("read", 32'({pslverr, prdata[15:0] & e[31:16]}), 32'({e[32], e[15:0] & e[31:16]}));
    end
  end
  initial begin
    step(20000);
    fails++;
    report_and_stop();
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(93027));
    {rst_b, moving, stepPulse, pulseCmdIn, inhibitInput, panelWrReq} = '0;
    posError = 16'h0100;
    step(12);
    rst_b <= 1'b1;
    rd(ipfm_pkg::OFF_DWELL, 16'h000A, 1'b0);
    rd(ipfm_pkg::OFF_INHIBIT, 16'h0003, 1'b0);
    rd(ipfm_pkg::OFF_LOCK, 16'h0000, 1'b0);
    rd(8'h34, 16'h0000, 1'b1);
    wr(ipfm_pkg::OFF_DWELL, 32'h0000_7531);
    rd(ipfm_pkg::OFF_DWELL, 16'h000A, 1'b0);
    wr(ipfm_pkg::OFF_DWELL, 32'h0000_7530);
    rd(ipfm_pkg::OFF_DWELL, 16'h7530, 1'b0);
    wr(ipfm_pkg::OFF_WINDOW, 32'h0000_8000);
    rd(ipfm_pkg::OFF_WINDOW, 16'h000A, 1'b0);
    wr(ipfm_pkg::OFF_WINDOW, 32'h0000_000C);
    rd(ipfm_pkg::OFF_WINDOW, 16'h000C, 1'b0);
    wr(ipfm_pkg::OFF_DWELL, 32'h0000_0003);
    // Dwell of three ticks, first stay cut short
    posError <= 16'h0005;
    step(8);
    posError <= 16'h0032;
    step(3);
    posError <= 16'h0005;
    step(10);
    chk("inPosition", 32'(inPosition), 32'h0);
    step(10);
    chk("inPosition", 32'(inPosition), 32'h1);
    wr(ipfm_pkg::OFF_FAULT, 32'h0000_0064);
    wr(ipfm_pkg::OFF_FAULT, 32'h0000_0000);
    posError <= 16'h0063;
    step(4);
    chk("positionFault", 32'(positionFault), 32'h0);
    posError <= 16'hFF9C;
    step(4);
    chk("positionFault", 32'(positionFault), 32'h1);
    wr(ipfm_pkg::OFF_MOTLIM, 32'h0000_0014);
    moving <= 1'b1;
    posError <= 16'h0015;
    step(3);
    chk("motionOut", 32'(motionOut), 32'h1);
    rd(ipfm_pkg::OFF_STATUS, 16'h0000, 1'b0);
    posError <= 16'h0014;
    step(3);
    chk("motionOut", 32'(motionOut), 32'h0);
    rd(ipfm_pkg::OFF_STATUS, 16'h0004, 1'b0);
    moving <= 1'b0;
    // Every inhibit code against both pin levels in mode 7
    wr(ipfm_pkg::OFF_CTRL, 32'h0000_0070);
    pulseCmdIn <= 1'b1;
    for (int c = 1; c < 4; c++) begin
      for (int p = 0; p < 2; p++) begin
        wr(ipfm_pkg::OFF_INHIBIT, 32'(c));
        inhibitInput <= p[0];
        step(6);
        chk("pulseCmdOut", 32'(pulseCmdOut), 32'(c == 1 ? !p[0] : c == 2 ? p[0] : 1'b1));
      end
    end
    wr(ipfm_pkg::OFF_INHIBIT, 32'h0000_0001);
    wr(ipfm_pkg::OFF_INHIBIT, 32'h0000_0000);
    rd(ipfm_pkg::OFF_INHIBIT, 16'h0001, 1'b0);
    wr(ipfm_pkg::OFF_CTRL, 32'h0000_0000);
    step(6);
    chk("pulseCmdOut", 32'(pulseCmdOut), 32'h1);
    panelWrReq <= 1'b1;
    wr(ipfm_pkg::OFF_LOCK, 32'h0000_0001);
    wr(ipfm_pkg::OFF_LOCK, 32'h0000_0002);
    step(2);
    chk("panelWrAllow", 32'(panelWrAllow), 32'h0);
    wr(ipfm_pkg::OFF_LOCK, 32'h0000_0000);
    step(2);
    chk("panelWrAllow", 32'(panelWrAllow), 32'h1);
    // idle level at half a random running level
    idleVal = 16'($urandom() >> 17);
    wr(ipfm_pkg::OFF_IRQMASK, 32'h0000_0004);
    wr(ipfm_pkg::OFF_IDLECUR, 32'(idleVal));
    step(3);
    chk("idleCurrent", 32'(idleCurrent), 32'(idleVal));
    chk("irq", 32'(irq), 32'h1);
    wr(ipfm_pkg::OFF_IRQSTAT, 32'h0000_0004);
    step(3);
    chk("irq", 32'(irq), 32'h0);
    wr(ipfm_pkg::OFF_CTRL, 32'h0000_0001);
    wr(ipfm_pkg::OFF_IDLEDLY, 32'h0000_0002);
    stepPulse <= 1'b1;
    step(1);
    stepPulse <= 1'b0;
    step(4);
    chk("idleActive", 32'(idleActive), 32'h0);
    step(14);
    chk("idleActive", 32'(idleActive), 32'h1);
    wr(ipfm_pkg::OFF_FAULT, 32'h0000_0065);
    rd(ipfm_pkg::OFF_FAULT, 16'h0064, 1'b0);
    chk("stallTorque", 32'(stallTorque), 32'h7F);
    rst_b <= 1'b0;
    step(2);
    rst_b <= 1'b1;
    rd(ipfm_pkg::OFF_INHIBIT, 16'h0003, 1'b0);
    step(2);
    chk("pending", 32'(expQ.size()), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
